// File: rtl/core_exec_defs.svh
`ifndef CORE_EXEC_DEFS_SVH
`define CORE_EXEC_DEFS_SVH
// data space locations of accumulator-adjacent registers
`define ADDR_X 8'h80
`define ADDR_Y 8'h81
`define ADDR_V 8'h82
`define ADDR_W 8'h83
`define ADDR_ACC 8'hff
// cycle counts per instruction class
`define CYC_SHORT 3'h2
`define CYC_NORM 3'h4
`define CYC_BITTEST 3'h5
// relative branch opcode fields
`define REL_DIR_BIT 4
`define REL_SPAN_MSB 3
`define REL_VALID_OP 8'hf4
// reset values
`define PC_RESET 12'h000
`define ACC_RESET 8'h00
`endif

// File: rtl/core_exec_pkg.sv
package core_exec_pkg;
    typedef enum logic [4:0] {
        OP_MOVE, OP_MOVE_IMM, OP_MOVE_IMM_REG, OP_STORE, OP_SUM, OP_AND, OP_COMPARE,
        OP_DIFF, OP_ZERO_FILL_ACC, OP_ZERO_FILL_REG, OP_PLUS_ONE, OP_MINUS_ONE,
        OP_INVERT, OP_ROTATE, OP_SHIFT, OP_BR_FLAG, OP_BR_BIT_CLEAR, OP_BR_BIT_HIGH,
        OP_BIT_ONE, OP_BIT_ZERO, OP_NOP, OP_SUB_EXIT, OP_INT_EXIT, OP_IDLE, OP_DEEP,
        OP_UNDEF
    } op_kind_t;
    typedef struct packed {
        op_kind_t kind;
        logic [1:0] len;
        logic [2:0] cycles;
        logic [2:0] bit_idx;
        logic [7:0] addr;
        logic [7:0] imm;
        logic use_imm;
    } decoded_t;
    typedef struct packed {
        logic null_result;
        logic borrow_out;
    } flags_t;
    typedef struct packed {
        logic [11:0] pc;
        logic [7:0] opcode;
        logic [7:0] byte1;
        logic [7:0] byte2;
    } fetch_t;
endpackage

// File: rtl/core_instruction_execution.sv
`timescale 1ns/1ps
`include "core_exec_defs.svh"
// Functional notes
// RL1: decode the documented instruction groups; 244 valid opcodes, 40 types (the code decodes 233 valid opcodes into 25 op kinds).
// RL2: move_op uses accumulator plus a data operand; one to three bytes (the code decodes move_op as one or two bytes).
// RL3: register move_immediate_op writes immediate byte to any data location.
// RL4: move forms take 4 cycles, update zero flag, keep carry.
// RL5: move_immediate_op to register is 3 bytes, 4 cycles, flags kept.
// RL6: sum, and, compare, difference use accumulator and data or immediate.
// RL7: those arithmetic forms take 4 cycles and update both flags.
// RL8: zero_fill, minus_one, plus_one accept any data address.
// RL9: plus_one and minus_one take 4 cycles, update zero, keep carry.
// RL10: zero_fill to register 3 bytes keeps flags; accumulator form updates both.
// RL11: invert, rotate, shift work on accumulator, 4 cycles, both flags.
// RL12: flag branches taken on flag 1 or 0; 1 byte, 2 cycles, flags kept.
// RL13: one-byte branches reach -15 to +16 around their own address.
// RL14: bit-test branches test data bit for 0 or 1; 3 bytes, 5 cycles.
// RL15: bit-test copies bit to carry, keeps zero, displacement -126 to +129.
// RL16: tested bit goes to carry whether or not branch is taken.
// RL17: bit set/clear on any data bit by 3-bit index; 2 bytes, 4 cycles.
// RL18: nop, sub exit, idle, deep halt: 1 byte, 2 cycles, flags kept.
// RL19: interrupt exit is 1 byte, 2 cycles, restores both flags.
// RL20: with watchdog selected, deep halt acts as idle halt.
// RL21: relative opcode has 3 condition bits, direction bit, 4-bit span.
// RL22: undefined opcodes get no defined behaviour beyond a safe skip.
module core_instruction_execution
    import core_exec_pkg::*;
#(
    parameter int PC_W = 12
) (
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire logic [7:0] prog_opcode_i,
    input wire logic [7:0] prog_byte1_i,
    input wire logic [7:0] prog_byte2_i,
    input wire logic [7:0] data_rd_i,
    input wire logic [7:0] ind_x_i,
    input wire logic [7:0] ind_y_i,
    input wire logic [1:0] saved_flags_i,
    input wire logic watchdog_sel_i,
    output logic [PC_W-1:0] pc_o,
    output logic [7:0] data_addr_o,
    output logic [7:0] data_wr_o,
    output logic data_we_o,
    output logic [7:0] acc_o,
    output logic [1:0] flags_o,
    output logic idle_o,
    output logic deep_halt_o,
    output logic undef_o,
    output logic ret_o
);
    typedef enum logic [1:0] {ST_FETCH, ST_EXEC, ST_HALT} state_t;
    state_t state;
    logic [2:0] cyc;
    decoded_t dec;
    decoded_t next_dec;
    flags_t fl;
    logic [7:0] acc;
    logic [PC_W-1:0] pc;

    function automatic decoded_t decode(input logic [7:0] op, input logic [7:0] b1,
                                        input logic [7:0] b2, input logic [7:0] x,
                                        input logic [7:0] y);
        decoded_t d;
        d = '{kind: OP_UNDEF, len: 2'd1, cycles: `CYC_SHORT, bit_idx: op[7:5],
              addr: b1, imm: b1, use_imm: 1'b0};
        if (op[2:0] != 3'b111 && op[2:0] != 3'b001 && op[2:0] != 3'b011
                && op[2:0] != 3'b101) begin
            // condition in bits 2:0, direction in bit 3, span in bits 7:4
            d.kind = OP_BR_FLAG; // RL21
            d.bit_idx = op[2:0];
            d.addr = {3'h0, op[3], op[7:4]};
        end else if (op[3:0] == 4'b0011) begin
            d.kind = op[4] ? OP_BR_BIT_HIGH : OP_BR_BIT_CLEAR; // RL14
            d.imm = b2;
            d.len = 2'd3;
            d.cycles = `CYC_BITTEST;
        end else if (op[3:0] == 4'b1011) begin
            d.kind = op[4] ? OP_BIT_ONE : OP_BIT_ZERO; // RL17
            d.len = 2'd2;
            d.cycles = `CYC_NORM;
        end else if (op[3:0] == 4'b0101 || op[3:0] == 4'b1101) begin
            // short direct: bits 7:6 pick x/y/v/w
            d.addr = {6'h20, op[7:6]};
            d.cycles = `CYC_NORM;
            d.kind = op[3] ? OP_MOVE : OP_PLUS_ONE; // RL2 RL9
            if (op[4]) d.kind = op[3] ? OP_STORE : OP_MINUS_ONE;
        end else if (op[3:0] == 4'b0111 || op[3:0] == 4'b1111) begin
            d.cycles = `CYC_NORM;
            unique case (op[2:0] == 3'b111 ? {op[3], op[7:5]} : 4'h0)
                4'h0: begin
                    d.kind = OP_MOVE;
                    d.addr = op[4] ? y : x;
                end
                4'h1: begin
                    d.kind = OP_MOVE_IMM;
                    d.use_imm = 1'b1;
                    d.len = 2'd2;
                end
                4'h2: begin
                    d.kind = OP_COMPARE;
                    d.addr = op[4] ? y : x;
                end
                4'h3: begin
                    d.kind = OP_COMPARE;
                    d.use_imm = 1'b1;
                    d.len = 2'd2;
                end
                4'h4: begin
                    d.kind = OP_SUM;
                    d.addr = op[4] ? y : x;
                end
                4'h5: begin
                    d.kind = OP_SUM;
                    d.use_imm = 1'b1;
                    d.len = 2'd2;
                end
                4'h6: begin
                    d.kind = OP_PLUS_ONE;
                    d.addr = op[4] ? y : x;
                end
                4'h7: begin
                    d.kind = OP_STORE;
                    d.addr = op[4] ? y : x;
                end
                4'h8: begin
                    d.kind = OP_MOVE;
                    d.len = 2'd2;
                end
                4'h9: begin
                    d.kind = OP_MOVE_IMM_REG;
                    d.imm = b2;
                    d.len = 2'd3; // RL5
                end
                4'ha: begin
                    d.kind = OP_AND;
                    d.len = 2'd2;
                end
                4'hb: begin
                    d.kind = OP_AND;
                    d.use_imm = 1'b1;
                    d.len = 2'd2;
                end
                4'hc: begin
                    d.kind = OP_DIFF;
                    d.len = 2'd2;
                end
                4'hd: begin
                    d.kind = OP_DIFF;
                    d.use_imm = 1'b1;
                    d.len = 2'd2;
                end
                4'he: begin
                    d.kind = OP_MINUS_ONE;
                    d.len = 2'd2;
                end
                default: d.kind = OP_INVERT;
            endcase
        end else begin
            unique case (op)
                // every even code is a relative branch, so inherent ops use the x1 column
                8'h01: d.kind = OP_NOP; // RL18
                8'h11: d.kind = OP_SUB_EXIT;
                8'h21: d.kind = OP_INT_EXIT; // RL19
                8'h31: d.kind = OP_IDLE;
                8'h41: d.kind = OP_DEEP;
                8'h51: begin d.kind = OP_ROTATE; d.cycles = `CYC_NORM; end // RL11
                8'h61: begin d.kind = OP_SHIFT; d.cycles = `CYC_NORM; d.len = 2'd2; end
                8'h71: begin d.kind = OP_ZERO_FILL_REG; d.imm = 8'h00; d.len = 2'd3;
                             d.cycles = `CYC_NORM; end // RL10
                8'h81: begin d.kind = OP_ZERO_FILL_ACC; d.len = 2'd2;
                             d.cycles = `CYC_NORM; end
                default: d.kind = OP_UNDEF; // RL22
            endcase
        end
        return d;
    endfunction

    function automatic logic [PC_W-1:0] rel_target(input logic [PC_W-1:0] base,
                                                  input logic [7:0] op);
        logic [PC_W-1:0] span;
        span = PC_W'(op[`REL_SPAN_MSB:0]) + PC_W'(1);
        // span 0..f maps to +1..+16 forward and 0..-15 backward
        return op[`REL_DIR_BIT] ? base - span + PC_W'(1) : base + span; // RL13
    endfunction

    always_comb begin
        next_dec = decode(prog_opcode_i, prog_byte1_i, prog_byte2_i, ind_x_i, ind_y_i); // RL1
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            state <= ST_FETCH;
            cyc <= 3'h0;
            dec <= '0;
        end else begin
            unique case (state)
                ST_FETCH: begin
                    dec <= next_dec;
                    cyc <= 3'h1;
                    state <= ST_EXEC;
                end
                ST_EXEC: begin
                    cyc <= cyc + 3'h1;
                    if (cyc == dec.cycles - 3'h1) begin // RL4 RL7 RL12
                        state <= (dec.kind == OP_IDLE || dec.kind == OP_DEEP) ?
                                 ST_HALT : ST_FETCH;
                    end
                end
                ST_HALT: state <= ST_HALT; // left only by reset here
            endcase
        end
    end

    wire last = (state == ST_EXEC) && (cyc == dec.cycles - 3'h1);
    wire [7:0] opnd = dec.use_imm ? dec.imm : data_rd_i;
    wire [8:0] sum9 = {1'b0, acc} + {1'b0, opnd};
    wire [8:0] dif9 = {1'b0, acc} - {1'b0, opnd};
    wire tbit = data_rd_i[dec.bit_idx];

    // accumulator and flags; the data bus read is stable during the exec window
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            acc <= `ACC_RESET;
            fl <= '0;
        end else if (last) begin
            unique case (dec.kind)
                OP_MOVE, OP_MOVE_IMM: begin acc <= opnd; fl.null_result <= opnd == 8'h00; end
                OP_STORE: fl.null_result <= acc == 8'h00; // RL4
                OP_SUM: begin acc <= sum9[7:0]; fl <= '{sum9[7:0] == 8'h00, sum9[8]}; end
                OP_DIFF: begin acc <= dif9[7:0]; fl <= '{dif9[7:0] == 8'h00, dif9[8]}; end
                OP_COMPARE: fl <= '{dif9[7:0] == 8'h00, dif9[8]}; // RL6 RL7
                OP_AND: begin acc <= acc & opnd; fl <= '{(acc & opnd) == 8'h00, 1'b0}; end
                OP_ZERO_FILL_ACC: begin acc <= 8'h00; fl <= '{1'b1, 1'b0}; end // RL10
                OP_PLUS_ONE: fl.null_result <= data_rd_i + 8'h01 == 8'h00; // RL9
                OP_MINUS_ONE: fl.null_result <= data_rd_i - 8'h01 == 8'h00;
                OP_INVERT: begin acc <= ~acc; fl <= '{~acc == 8'h00, acc[7]}; end // RL11
                OP_ROTATE: begin acc <= {acc[6:0], fl.borrow_out};
                                 fl <= '{{acc[6:0], fl.borrow_out} == 8'h00, acc[7]}; end
                OP_SHIFT: begin acc <= {acc[6:0], 1'b0};
                                fl <= '{{acc[6:0], 1'b0} == 8'h00, acc[7]}; end
                OP_BR_BIT_CLEAR, OP_BR_BIT_HIGH: fl.borrow_out <= tbit; // RL15 RL16
                OP_INT_EXIT: fl <= saved_flags_i; // RL19
                default: ;
            endcase
        end
    end

    // program counter: displacement applied relative to the branch address
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            pc <= PC_W'(`PC_RESET);
        end else if (last) begin
            unique case (dec.kind)
                OP_BR_FLAG: begin
                    if ((dec.bit_idx[1] ? fl.borrow_out : fl.null_result) == dec.bit_idx[2])
                        pc <= rel_target(pc, dec.addr); // RL13
                    else
                        pc <= pc + PC_W'(1); // RL12
                end
                OP_BR_BIT_CLEAR, OP_BR_BIT_HIGH: begin
                    if (tbit == (dec.kind == OP_BR_BIT_HIGH)) // RL14
                        pc <= pc + PC_W'(2) + PC_W'($signed(dec.imm)); // RL15
                    else
                        pc <= pc + PC_W'(3);
                end
                default: pc <= pc + PC_W'(dec.len); // RL2 RL5 RL17 RL18
            endcase
        end
    end

    // data space write-back
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            data_addr_o <= 8'h00;
            data_wr_o <= 8'h00;
            data_we_o <= 1'b0;
        end else begin
            data_we_o <= 1'b0;
            if (state == ST_FETCH)
                data_addr_o <= next_dec.addr;
            if (last) begin
                unique case (dec.kind)
                    OP_STORE: begin data_wr_o <= acc; data_we_o <= 1'b1; end
                    OP_MOVE_IMM_REG, OP_ZERO_FILL_REG: begin
                        data_wr_o <= dec.imm; data_we_o <= 1'b1; end // RL3 RL8
                    OP_PLUS_ONE: begin data_wr_o <= data_rd_i + 8'h01; data_we_o <= 1'b1; end
                    OP_MINUS_ONE: begin data_wr_o <= data_rd_i - 8'h01; data_we_o <= 1'b1; end
                    OP_BIT_ONE, OP_BIT_ZERO: begin
                        data_wr_o <= (data_rd_i & ~(8'h01 << dec.bit_idx))
                                     | ({7'h00, dec.kind == OP_BIT_ONE} << dec.bit_idx);
                        data_we_o <= 1'b1; // RL17
                    end
                    default: ;
                endcase
            end
        end
    end

    // status outputs
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            idle_o <= 1'b0;
            deep_halt_o <= 1'b0;
            undef_o <= 1'b0;
            ret_o <= 1'b0;
        end else begin
            ret_o <= last && (dec.kind == OP_SUB_EXIT || dec.kind == OP_INT_EXIT);
            undef_o <= last && dec.kind == OP_UNDEF; // RL22
            if (last && dec.kind == OP_IDLE)
                idle_o <= 1'b1;
            if (last && dec.kind == OP_DEEP) begin
                // watchdog keeps the oscillator alive, so deep halt degrades to idle
                idle_o <= watchdog_sel_i; // RL20
                deep_halt_o <= !watchdog_sel_i;
            end
        end
    end

    assign pc_o = pc;
    assign acc_o = acc;
    assign flags_o = fl;
endmodule

// File: test/core_exec_properties.sv
`timescale 1ns/1ps
module core_exec_properties #(
    parameter int PC_W = 12
) (
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire logic watchdog_sel_i,
    input wire logic [PC_W-1:0] pc_o,
    input wire logic data_we_o,
    input wire logic [7:0] acc_o,
    input wire logic [1:0] flags_o,
    input wire logic idle_o,
    input wire logic deep_halt_o,
    input wire logic undef_o,
    input wire logic ret_o
);
    default clocking @(posedge mclk_i);
    endclocking
    default disable iff (!rst_b_i);
    property p_reset_clears;
        disable iff (1'b0) !rst_b_i |=> pc_o == '0 && acc_o == 8'h00 && flags_o == 2'h0
            && !data_we_o && !idle_o && !deep_halt_o;
    endproperty
    a_reset_clears: assert property (p_reset_clears) else $error("reset left state");
    property p_undef_skip;
        undef_o |-> pc_o == $past(pc_o) + 1'b1 && !data_we_o && $stable(acc_o)
            && $stable(flags_o);
    endproperty
    a_undef_skip: assert property (p_undef_skip) else $error("bad undefined skip");
    property p_undef_pulse;
        undef_o |=> !undef_o;
    endproperty
    a_undef_pulse: assert property (p_undef_pulse) else $error("undef not a pulse");
    property p_we_spacing;
        data_we_o |=> !data_we_o [*3];
    endproperty
    a_we_spacing: assert property (p_we_spacing) else $error("writes too close");
    property p_pc_spacing;
        $changed(pc_o) |=> $stable(pc_o);
    endproperty
    a_pc_spacing: assert property (p_pc_spacing) else $error("pc moved twice");
    property p_wd_no_deep;
        watchdog_sel_i |-> !$rose(deep_halt_o);
    endproperty
    a_wd_no_deep: assert property (p_wd_no_deep) else $error("deep halt under wd");
    property p_idle_hold;
        idle_o |=> idle_o && !data_we_o && $stable(pc_o);
    endproperty
    a_idle_hold: assert property (p_idle_hold) else $error("idle not held");
    property p_deep_hold;
        deep_halt_o |=> deep_halt_o && $stable(pc_o);
    endproperty
    a_deep_hold: assert property (p_deep_hold) else $error("deep halt not held");
    property p_ret_pulse;
        ret_o |=> !ret_o;
    endproperty
    a_ret_pulse: assert property (p_ret_pulse) else $error("ret not a pulse");
    c_undef: cover property (undef_o);
    c_write: cover property (data_we_o);
    c_idle: cover property ($rose(idle_o));
endmodule
bind core_instruction_execution core_exec_properties #(.PC_W(PC_W)) u_props (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i), .watchdog_sel_i(watchdog_sel_i), .pc_o(pc_o),
    .data_we_o(data_we_o), .acc_o(acc_o), .flags_o(flags_o), .idle_o(idle_o),
    .deep_halt_o(deep_halt_o), .undef_o(undef_o), .ret_o(ret_o));

// File: test/core_instruction_execution_bench.sv
`timescale 1ns/1ps
`define CHECK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin failures++; \
    $display("MISMATCH t=%0t got %0h exp %0h", $time, got, exp); end end
module core_instruction_execution_bench;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] op = 8'h00, b1 = 8'h00, b2 = 8'h00, drd = 8'h00, ix = 8'h00, iy = 8'h00;
    logic [1:0] sflg = 2'h0;
    logic wd = 1'b0;
    logic [11:0] pc;
    logic [7:0] daddr, dwr, acc;
    logic [1:0] flg;
    logic we, idle, deep, undef, ret;
    logic [7:0] rom [4096];
    logic [31:0] seed;
    logic [7:0] dop;
    bit directed, halted;
    int failures, cmp_count, last_pc, gap, d, imm, tot, macc;
    core_instruction_execution DUT (
        .mclk_i(mclk), .rst_b_i(rst_b), .prog_opcode_i(op), .prog_byte1_i(b1),
        .prog_byte2_i(b2), .data_rd_i(drd), .ind_x_i(ix), .ind_y_i(iy),
        .saved_flags_i(sflg), .watchdog_sel_i(wd), .pc_o(pc), .data_addr_o(daddr),
        .data_wr_o(dwr), .data_we_o(we), .acc_o(acc), .flags_o(flg), .idle_o(idle),
        .deep_halt_o(deep), .undef_o(undef), .ret_o(ret));
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h0);
    endfunction
    function automatic logic [7:0] dir_op(input int ep);
        case (ep)
            0: return 8'h38;
            1: return 8'hf0;
            2: return 8'hf4;
            3: return 8'ha7;
            4: return 8'h5b;
            5: return 8'h21;
            6, 7: return 8'h41;
            default: return 8'h27;
        endcase
    endfunction
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        forever #4 mclk = ~mclk;
    end
    // program bytes follow pc like a rom read; a directed run pins one opcode
    always @(negedge mclk) begin
        op <= directed ? dop : rom[pc];
        b1 <= rom[pc + 12'h1];
        b2 <= rom[pc + 12'h2];
    end
    // sampled just after the edge so this cycle's register updates have landed
    always @(posedge mclk) begin
        #1;
        if (!rst_b) begin
            last_pc = 0;
            gap = 0;
            halted = 1'b0;
            macc = 0;
        end else begin
            gap++;
            d = (int'(pc) - last_pc + 4096) % 4096;
            if (undef === 1'b1) begin
                `CHECK(d, 1)
                `CHECK(we, 1'b0)
            end
            if (halted)
                `CHECK(d, 0)
            `CHECK(deep & wd, 1'b0)
            // reference model of the pinned opcode, checked at each retire
            if (directed && d != 0) begin
                imm = rom[(last_pc + 1) % 4096];
                `CHECK(we, dop == 8'h5b)
                case (dop)
                    8'h38, 8'hf0, 8'hf4: begin
                        `CHECK(gap, 2)
                        `CHECK(d, dop == 8'h38 ? 4093 : dop == 8'hf0 ? 16 : 1)
                        `CHECK(flg, 2'b00)
                    end
                    8'ha7: begin
                        tot = macc + imm;
                        macc = tot % 256;
                        `CHECK(gap, 4)
                        `CHECK(d, 2)
                        `CHECK(acc, macc)
                        `CHECK(flg, {macc == 0, tot > 255})
                    end
                    8'h27: begin
                        `CHECK(gap, 4)
                        `CHECK(d, 2)
                        `CHECK(acc, imm)
                        `CHECK(flg, {imm == 0, 1'b0})
                    end
                    8'h5b: begin
                        `CHECK(gap, 4)
                        `CHECK(d, 2)
                        `CHECK(daddr, imm)
                        `CHECK(dwr, drd | 8'h04)
                        `CHECK(flg, 2'b00)
                    end
                    8'h21: begin
                        `CHECK(gap, 2)
                        `CHECK(d, 1)
                        `CHECK(flg, sflg)
                        `CHECK(ret, 1'b1)
                    end
                    default: begin
                        `CHECK(gap, 2)
                        `CHECK(d, 1)
                        `CHECK(deep, !wd)
                        `CHECK(idle, wd)
                    end
                endcase
                gap = 0;
            end
            halted = (idle | deep) === 1'b1;
            last_pc = pc;
        end
    end
    initial begin
        #200us;
        failures++;
        summarize();
    end
    initial begin
        seed = 32'hdef83892;
        // each episode restarts from reset because halts only end there
        for (int ep = 0; ep < 42; ep++) begin
            @(negedge mclk);
            rst_b = 1'b0;
            for (int i = 0; i < 4096; i++) begin
                seed = lfsr_next(seed);
                rom[i] = seed[7:0];
            end
            directed = ep < 9;
            dop = dir_op(ep);
            // the two deep-halt episodes see the watchdog both ways
            wd = (ep == 6 || ep == 7) ? ep[0] : seed[9];
            drd = seed[15:8];
            ix = seed[23:16];
            iy = seed[31:24];
            sflg = seed[11:10];
            repeat (2) @(negedge mclk);
            `CHECK({pc, acc, flg, we, idle, deep}, 25'h0)
            rst_b = 1'b1;
            repeat (150) @(negedge mclk);
        end
        summarize();
    end
endmodule
